// ===== hdl/tap_port.sv
// Boundary-scan test access port controller with IR, ID and bypass registers
// Contract
// - Mode select and data in are sampled at rising test clock edges, which alone advance.
// - Outputs other than ready, test data out among them, change only on falling test clock edges or at test reset.
// - Each rising edge in a shift state moves one input bit into the selected register.
// - In a shift state data out shows the selected register, changed on falling edges.
// - Data out is released except in the data or instruction register shift state.
// - The tester steers the controller by mode select and it follows each transition.
// - An asserted test reset resets the controller at once, without a test clock edge.
// - The controller does not reset itself at power-up and waits for an explicit reset.
// - Test reset or five high mode-select cycles in a row put the controller in reset.
// - Until the controller has been properly reset, its outputs stay released.
`timescale 1ns/1ps
`include "tap_map.svh"
module tap_port #(
   parameter int IR_WIDTH = `TAP_IR_WIDTH,
   parameter int DR_WIDTH = `TAP_DR_WIDTH,
   // Arbitrary identification value, bit zero set as the standard wants
   parameter logic [DR_WIDTH-1:0] IDCODE_VALUE = `TAP_IDCODE_VALUE
) (
   // System clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // Test pins from the tester
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   input wire logic TEST_RESET_N,
   // Serial data out, enable high while driven
   output logic TDO,
   output logic TDO_EN,
   // Controller status
   output logic TAP_READY,
   output logic TEST_LOGIC_RESET
);

   tap_pins_if pins ();

   tap_pin_sampler sampler (
      .clock(CLOCK),
      .reset(RESET),
      .tck(TCK),
      .tms(TMS),
      .tdi(TDI),
      .trst_n(TEST_RESET_N),
      .pins(pins.sampler)
   );

   tap_pkg::tap_state_type state;
   tap_pkg::tap_state_type next_state;
   logic ready;
   logic next_ready;
   logic [`TAP_COUNT_WIDTH-1:0] high_count;
   logic [`TAP_COUNT_WIDTH-1:0] next_high_count;
   logic [IR_WIDTH-1:0] ir;
   logic [IR_WIDTH-1:0] next_ir;
   logic [IR_WIDTH-1:0] ir_shift;
   logic [IR_WIDTH-1:0] next_ir_shift;
   logic [DR_WIDTH-1:0] dr_shift;
   logic [DR_WIDTH-1:0] next_dr_shift;
   logic tdo;
   logic next_tdo;
   logic tdo_en;
   logic next_tdo_en;
   logic in_reset;
   logic next_in_reset;
   logic id_selected;

   // Standard sixteen-state transition on mode select
   function automatic tap_pkg::tap_state_type step(input tap_pkg::tap_state_type s,
                                                   input logic m);
      unique case (s)
         tap_pkg::TEST_LOGIC_RESET: step = m ? tap_pkg::TEST_LOGIC_RESET : tap_pkg::RUN_TEST_IDLE;
         tap_pkg::RUN_TEST_IDLE: step = m ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
         tap_pkg::SELECT_DR: step = m ? tap_pkg::SELECT_IR : tap_pkg::CAPTURE_DR;
         tap_pkg::CAPTURE_DR: step = m ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
         tap_pkg::SHIFT_DR: step = m ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
         tap_pkg::EXIT1_DR: step = m ? tap_pkg::UPDATE_DR : tap_pkg::PAUSE_DR;
         tap_pkg::PAUSE_DR: step = m ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
         tap_pkg::EXIT2_DR: step = m ? tap_pkg::UPDATE_DR : tap_pkg::SHIFT_DR;
         tap_pkg::UPDATE_DR: step = m ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
         tap_pkg::SELECT_IR: step = m ? tap_pkg::TEST_LOGIC_RESET : tap_pkg::CAPTURE_IR;
         tap_pkg::CAPTURE_IR: step = m ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
         tap_pkg::SHIFT_IR: step = m ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
         tap_pkg::EXIT1_IR: step = m ? tap_pkg::UPDATE_IR : tap_pkg::PAUSE_IR;
         tap_pkg::PAUSE_IR: step = m ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
         tap_pkg::EXIT2_IR: step = m ? tap_pkg::UPDATE_IR : tap_pkg::SHIFT_IR;
         tap_pkg::UPDATE_IR: step = m ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
      endcase
   endfunction

   // Unknown codes fall back to bypass, never to a dead chain
   assign id_selected = (ir == IR_WIDTH'(`TAP_INSTR_IDCODE));

   // Controller and scan registers, moved on rising test clock or at test reset only
   always_comb begin
      next_state = state;
      next_ready = ready;
      next_high_count = high_count;
      next_ir = ir;
      next_ir_shift = ir_shift;
      next_dr_shift = dr_shift;
      if (pins.trst_active) begin
         // Level-sensitive, needs no test clock edge
         next_state = tap_pkg::TEST_LOGIC_RESET;
         next_ready = 1'b1;
         next_high_count = `TAP_COUNT_WIDTH'(0);
         next_ir = IR_WIDTH'(`TAP_INSTR_IDCODE);
      end else if (pins.tck_rise) begin
         next_state = step(state, pins.tms);
         if (!pins.tms) begin
            next_high_count = `TAP_COUNT_WIDTH'(0);
         end else if (high_count != `TAP_RESET_TMS_COUNT) begin
            next_high_count = high_count + `TAP_COUNT_WIDTH'(1);
         end
         // Fifth high edge proves the machine sits in reset
         if (pins.tms && high_count == `TAP_RESET_TMS_COUNT - `TAP_COUNT_WIDTH'(1)) begin
            next_ready = 1'b1;
         end
         unique case (state)
            tap_pkg::TEST_LOGIC_RESET: begin
               next_ir = IR_WIDTH'(`TAP_INSTR_IDCODE);
            end
            tap_pkg::CAPTURE_IR: begin
               next_ir_shift = IR_WIDTH'(`TAP_IR_CAPTURE);
            end
            tap_pkg::SHIFT_IR: begin
               next_ir_shift = {pins.tdi, ir_shift[IR_WIDTH-1:1]};
            end
            tap_pkg::UPDATE_IR: begin
               next_ir = ir_shift;
            end
            tap_pkg::CAPTURE_DR: begin
               next_dr_shift = id_selected ? IDCODE_VALUE : '0;
            end
            tap_pkg::SHIFT_DR: begin
               if (id_selected) begin
                  next_dr_shift = {pins.tdi, dr_shift[DR_WIDTH-1:1]};
               end else begin
                  // Bypass is the single bit at position zero
                  next_dr_shift = {dr_shift[DR_WIDTH-1:1], pins.tdi};
               end
            end
            default: begin
               next_ir_shift = ir_shift;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         // Power-up leaves the port unproven; outputs stay released
         state <= tap_pkg::TEST_LOGIC_RESET;
         ready <= 1'b0;
         high_count <= `TAP_COUNT_WIDTH'(0);
         ir <= IR_WIDTH'(`TAP_INSTR_IDCODE);
         ir_shift <= IR_WIDTH'(0);
         dr_shift <= '0;
      end else begin
         state <= next_state;
         ready <= next_ready;
         high_count <= next_high_count;
         ir <= next_ir;
         ir_shift <= next_ir_shift;
         dr_shift <= next_dr_shift;
      end
   end

   // Outputs, moved on falling test clock or at test reset only
   always_comb begin
      next_tdo = tdo;
      next_tdo_en = tdo_en;
      next_in_reset = in_reset;
      if (pins.trst_active) begin
         next_tdo_en = 1'b0;
         next_in_reset = 1'b1;
      end else if (pins.tck_fall) begin
         next_tdo = (state == tap_pkg::SHIFT_IR) ? ir_shift[0] : dr_shift[0];
         next_tdo_en = ready && (state == tap_pkg::SHIFT_IR ||
                                 state == tap_pkg::SHIFT_DR);
         next_in_reset = (state == tap_pkg::TEST_LOGIC_RESET);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         tdo <= 1'b0;
         tdo_en <= 1'b0;
         in_reset <= 1'b1;
      end else begin
         tdo <= next_tdo;
         tdo_en <= next_tdo_en;
         in_reset <= next_in_reset;
      end
   end

   assign TDO = tdo;
   assign TDO_EN = tdo_en;
   assign TAP_READY = ready;
   assign TEST_LOGIC_RESET = in_reset;

endmodule

// ===== hdl/tap_map.svh
// Constants of the boundary-scan test port
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH

`define TAP_IR_WIDTH 4
`define TAP_DR_WIDTH 32
`define TAP_IR_CAPTURE 4'h1
`define TAP_INSTR_IDCODE 4'h2
`define TAP_INSTR_BYPASS 4'hf
`define TAP_IDCODE_VALUE 32'h00000001
`define TAP_RESET_TMS_COUNT 3'h5
`define TAP_COUNT_WIDTH 3

`endif

// ===== hdl/tap_pkg.sv
// Types of the boundary-scan test port
package tap_pkg;

   typedef enum logic [3:0] {
      TEST_LOGIC_RESET,
      RUN_TEST_IDLE,
      SELECT_DR,
      CAPTURE_DR,
      SHIFT_DR,
      EXIT1_DR,
      PAUSE_DR,
      EXIT2_DR,
      UPDATE_DR,
      SELECT_IR,
      CAPTURE_IR,
      SHIFT_IR,
      EXIT1_IR,
      PAUSE_IR,
      EXIT2_IR,
      UPDATE_IR
   } tap_state_type;

endpackage

// ===== hdl/tap_pins_if.sv
// Sampled test pins passed from the pin sampler to the controller
`timescale 1ns/1ps
interface tap_pins_if;
   logic tck_rise;
   logic tck_fall;
   logic tms;
   logic tdi;
   logic trst_active;

   modport sampler (
      output tck_rise,
      output tck_fall,
      output tms,
      output tdi,
      output trst_active
   );

   modport controller (
      input tck_rise,
      input tck_fall,
      input tms,
      input tdi,
      input trst_active
   );
endinterface

// ===== hdl/tap_pin_sampler.sv
// Three-stage sampler and edge finder for the test pins
`timescale 1ns/1ps
module tap_pin_sampler (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Raw pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   // Sampled pins
   tap_pins_if.sampler pins
);

   // Bit order: tck, tms, tdi, trst_n
   logic [3:0] stage1;
   logic [3:0] stage2;
   logic [3:0] stage3;
   logic [3:0] level;
   logic rise;
   logic fall;
   logic [3:0] next_level;
   logic next_rise;
   logic next_fall;

   // A level counts only once stages two and three agree
   always_comb begin
      next_level = (stage2 & stage3) | (level & (stage2 | stage3));
      next_rise = ~level[3] & next_level[3];
      next_fall = level[3] & ~next_level[3];
   end

   // Stages run through reset, so a test reset tied to the system reset is still seen
   always_ff @(posedge clock) begin
      stage1 <= {tck, tms, tdi, trst_n};
      stage2 <= stage1;
      stage3 <= stage2;
      if (reset) begin
         // Idle pin levels, else a false test reset follows every reset
         level <= 4'h7;
         rise <= 1'b0;
         fall <= 1'b0;
      end else begin
         level <= next_level;
         rise <= next_rise;
         fall <= next_fall;
      end
   end

   // Mode select and data in travel the same pipe as the clock edge
   assign pins.tck_rise = rise;
   assign pins.tck_fall = fall;
   assign pins.tms = level[2];
   assign pins.tdi = level[1];
   assign pins.trst_active = ~level[0];

endmodule

// ===== tb/tap_port_sva.sv
// Checker of the test port's output timing and reset behaviour
`timescale 1ns/1ps
module tap_port_sva (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // Test pins
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   input wire logic TEST_RESET_N,
   // Port outputs
   input wire logic TDO,
   input wire logic TDO_EN,
   input wire logic TAP_READY,
   input wire logic TEST_LOGIC_RESET
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RESET);

   en_needs_ready_a: assert property (TDO_EN |-> TAP_READY)
      else $error("output driven before proper reset");
   power_up_a: assert property ($fell(RESET) |->
      !TAP_READY && TEST_LOGIC_RESET && !TDO_EN)
      else $error("power-up left the port ready or driving");
   trst_force_a: assert property (!TEST_RESET_N [*6] |->
      TEST_LOGIC_RESET && TAP_READY && !TDO_EN)
      else $error("test reset did not force the reset state");
   reset_quiet_a: assert property (TEST_LOGIC_RESET |-> !TDO_EN)
      else $error("output driven in reset state");
   idle_still_a: assert property ((!TCK && TEST_RESET_N) [*8] |->
      $stable(TDO) && $stable(TDO_EN) && $stable(TAP_READY))
      else $error("output moved without a test clock edge");
   ready_sticky_a: assert property (TAP_READY |=> TAP_READY)
      else $error("ready dropped without power-up reset");
   en_rise_a: assert property ($rose(TDO_EN) |-> !TEST_LOGIC_RESET && TAP_READY)
      else $error("output enabled outside a shift");
   tdo_hold_a: assert property ($changed(TDO) |=> $stable(TDO) [*4])
      else $error("data out changed twice within one test clock");
endmodule
bind tap_port tap_port_sva i_sva (.CLOCK(CLOCK), .RESET(RESET), .TCK(TCK), .TMS(TMS),
   .TDI(TDI), .TEST_RESET_N(TEST_RESET_N), .TDO(TDO), .TDO_EN(TDO_EN),
   .TAP_READY(TAP_READY), .TEST_LOGIC_RESET(TEST_LOGIC_RESET));

// ===== tb/tap_tester.sv
// Model of the external test controller
`timescale 1ns/1ps
module tap_tester (
   // Bench clock
   input wire logic clk,
   // Pins toward the port
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n,
   // Pins from the port
   input wire logic tdo,
   input wire logic tdo_en
);
   // Pulled-up pins idle high; clock stands low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst_n = 1'b1;
   end

   // One 200 ns test clock; data out read late, it trails the falling edge
   task automatic step(input logic m, input logic d, output logic [1:0] seen);
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
      tck = 1'b1;
      repeat (4) @(negedge clk);
      seen = tdo_en ? {1'b1, tdo} : 2'b00;
      tck = 1'b0;
   endtask

   // Test reset wired to the system reset, as on a board with no driver of its own
   task automatic follow_reset(input logic active);
      trst_n = ~active;
   endtask

   task automatic reset_pulse;
      trst_n = 1'b0;
      repeat (8) @(negedge clk);
      trst_n = 1'b1;
      repeat (5) @(negedge clk);
   endtask
endmodule

// ===== tb/boundary_scan_tap_port_tb.sv
// Self-checking bench of the boundary-scan test port
`timescale 1ns/1ps
`include "tap_map.svh"
module boundary_scan_tap_port_tb;
   logic clock;
   logic reset;
   logic tck, tms, tdi, trst_n, tdo, tdo_en, ready, tlr;
   int err_count;
   int compares;

   tap_port i_dut (.CLOCK(clock), .RESET(reset), .TCK(tck), .TMS(tms), .TDI(tdi),
      .TEST_RESET_N(trst_n), .TDO(tdo), .TDO_EN(tdo_en), .TAP_READY(ready),
      .TEST_LOGIC_RESET(tlr));
   tap_tester i_tester (.clk(clock), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
      .tdo(tdo), .tdo_en(tdo_en));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic results;
      if (err_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Mode-select path, first step in bit 0; then settle past the output delay
   task automatic walk(input logic [7:0] path, input int n);
      logic [1:0] s;
      for (int i = 0; i < n; i++) begin
         i_tester.step(path[i], 1'b1, s);
      end
      repeat (8) @(negedge clock);
   endtask

   task automatic shift(input int n, input logic [31:0] din, input logic ex,
      output logic [31:0] dout, output logic [31:0] en);
      logic [1:0] s;
      dout = '0;
      en = '0;
      for (int i = 0; i < n; i++) begin
         i_tester.step(ex && i == n - 1, din[i], s);
         dout[i] = s[0];
         en[i] = s[1];
      end
   endtask

   task automatic t_power_up;
      logic [31:0] d, e;
      check(ready, 1'b0, "ready after power-up");
      check(tlr, 1'b1, "reset state after power-up");
      walk(8'h06, 5);
      shift(4, 32'h0, 1'b0, d, e);
      check(e, 32'h0, "enable before proper reset");
   endtask

   task automatic t_tms_reset;
      walk(8'h0f, 5);
      check(ready, 1'b0, "ready after four highs");
      walk(8'h1f, 5);
      check(ready, 1'b1, "ready after five highs");
      check(tlr, 1'b1, "reset state after five highs");
   endtask

   task automatic t_scan_bypass;
      logic [31:0] d, e;
      logic [1:0] s;
      walk(8'h06, 5);
      shift(4, {28'h0, `TAP_INSTR_BYPASS}, 1'b1, d, e);
      check(d, {28'h0, `TAP_IR_CAPTURE}, "instruction capture");
      check(e, 32'hf, "enable in instruction shift");
      i_tester.step(1'b1, 1'b1, s);
      check({30'h0, s}, 32'h0, "released after exit");
      walk(8'h02, 4);
      shift(8, 32'ha5, 1'b1, d, e);
      check(d, 32'h4a, "bypass one-bit delay");
      check(e, 32'hff, "enable in data shift");
   endtask

   task automatic t_test_reset;
      logic [31:0] d, e;
      logic [1:0] s;
      i_tester.step(1'b1, 1'b1, s);
      walk(8'h02, 4);
      i_tester.step(1'b0, 1'b1, s);
      check({30'h0, s}, 32'h2, "bypass driven");
      i_tester.reset_pulse();
      check(tdo_en, 1'b0, "released by test reset");
      check(tlr, 1'b1, "reset state by test reset");
      walk(8'h02, 4);
      shift(32, 32'h0, 1'b1, d, e);
      check(d, `TAP_IDCODE_VALUE, "identification after reset");
      check(e, 32'hffffffff, "enable in id shift");
   endtask

   task automatic t_tied_reset;
      @(negedge clock);
      reset = 1'b1;
      i_tester.follow_reset(1'b1);
      repeat (5) @(negedge clock);
      reset = 1'b0;
      i_tester.follow_reset(1'b0);
      repeat (5) @(negedge clock);
      check(ready, 1'b1, "ready after tied reset");
      check(tlr, 1'b1, "reset state after tied reset");
      check(tdo_en, 1'b0, "released after tied reset");
   endtask

   initial begin
      err_count = 0;
      compares = 0;
      reset = 1'b1;
      repeat (5) @(negedge clock);
      reset = 1'b0;
      repeat (5) @(negedge clock);
      t_power_up;
      t_tms_reset;
      t_scan_bypass;
      t_test_reset;
      t_tied_reset;
      results;
   end

   // About ten times the expected run
   initial begin
      #200000;
      err_count++;
      results;
   end
endmodule
